//--- design/fer_cfg.svh
`ifndef FER_CFG_SVH
`define FER_CFG_SVH

// Serial register port geometry
`define FER_ADDR_W        7
`define FER_DATA_W        8
`define FER_FRAME_BITS    16

// Register offsets
`define FER_ADDR_SWRESET  7'h00
`define FER_ADDR_LOWPWR   7'h07
`define FER_ADDR_TEST     7'h0d
`define FER_ADDR_BIAS     7'h13

// Field positions
`define FER_SWRESET_BIT   5
`define FER_LOWPWR_BIT    4
`define FER_ALOOP_BIT     7
`define FER_DLOOP_BIT     6
`define FER_RXTRI_BIT     5
`define FER_CGA_MSB       7
`define FER_CGA_LSB       5
`define FER_SGA_MSB       4
`define FER_SGA_LSB       3
`define FER_CONV_MSB      2
`define FER_CONV_LSB      0

// Converter bias code forced by the low-power bit
`define FER_LOWPWR_BIAS   3'h3

// Reset values; low-power register depends on {duplex, config} straps
`define FER_LOWPWR_RST_H0 8'h00
`define FER_LOWPWR_RST_H1 8'h00
`define FER_LOWPWR_RST_F0 8'h00
`define FER_LOWPWR_RST_F1 8'h00
`define FER_TEST_RST      8'h00
`define FER_BIAS_RST      8'h00

// Cycles after system reset spent loading strap defaults
`define FER_INIT_CYCLES   2'h3

`endif

//--- design/fer_ctrl.sv
`timescale 1ns/1ps
`include "fer_cfg.svh"

// Overview of operation
// - The duplex strap picks half duplex when low, full duplex when high.
// - Duplex and config straps together pick the register default set.
// - With the serial enable held high the serial port does nothing.
// - Reset pin or software reset bit reloads the strap-chosen defaults.
// - Calibration starts after a pin reset or a system reset with the pin high, never a software reset.
// - Pin and software resets leave the transmit filter data; system reset clears it.
// - Registers take defaults while the pin is low; calibration on rise.
// - Analog loopback feeds converter output into the transmit path.
// - Digital loopback in full duplex copies transmit port to receive.
// - The receive-port tristate bit floats the receive port.
// - Bias register holds three fields at bits 7:5, 4:3 and 2:0.
// - Bias register resets to zero, nominal bias everywhere.
// - Converter low-power bit acts as converter bias code 011.

module fer_ctrl #(
  parameter int ADDR_W = `FER_ADDR_W,
  parameter int DATA_W = `FER_DATA_W
)(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        resetPinN,
  input  wire logic        duplexSelPin,
  input  wire logic        configSelPin,
  input  wire logic        serialClk,
  input  wire logic        serialPortEnableN,
  input  wire logic        serialDataIn,
  output logic             serialDataOut,
  output logic             serialDataOeN,
  input  wire logic [5:0]  txPortData,
  input  wire logic [5:0]  rxCoreData,
  input  wire logic [11:0] txPathData,
  input  wire logic [11:0] adcData,
  output logic             fullDuplexMode,
  output logic             calStart,
  output logic [11:0]      interpFilterIn,
  output logic [5:0]       rxPortData,
  output logic             rxPortOeN,
  output logic [2:0]       contGainBias,
  output logic [1:0]       switchedGainBias,
  output logic [2:0]       convBias
);

  if (DATA_W != 8 || ADDR_W != 7) begin : gBadWidth
    $error("fer_ctrl: register port is 7-bit address, 8-bit data");
  end

  // Every field must sit inside the register byte
  if (`FER_CGA_MSB >= DATA_W || `FER_SWRESET_BIT >= DATA_W ||
      `FER_ALOOP_BIT >= DATA_W || `FER_LOWPWR_BIT >= DATA_W)
  begin : gBadField
    $error("fer_ctrl: register field outside the data byte");
  end

  logic [2:0]             pinMeta_q, pinMeta_d;
  logic [2:0]             pinSync_q, pinSync_d;
  logic                   resetPrev_q, resetPrev_d;
  logic                   cal_q, cal_d;
  logic [1:0]             initCnt_q, initCnt_d;
  logic                   swReset_q, swReset_d;
  fer_pkg::fer_if_mode_t  mode_q, mode_d;
  logic [DATA_W-1:0]      lowPwr_q, lowPwr_d;
  logic [DATA_W-1:0]      test_q, test_d;
  logic [DATA_W-1:0]      bias_q, bias_d;
  logic [11:0]            filt_q, filt_d;
  logic [5:0]             rxPort_q, rxPort_d;
  logic                   rxOeN_q, rxOeN_d;
  logic [2:0]             convBias_q, convBias_d;
  logic                   wrStrobe;
  logic [ADDR_W-1:0]      regAddr;
  logic [DATA_W-1:0]      wrData;
  logic [DATA_W-1:0]      rdData;
  logic                   hwResetLow;
  logic                   loadDefaults;

  // Strap-dependent default for the converter low-power register
  function automatic logic [7:0] defaultLowPower(input logic duplex,
                                                 input logic cfgStrap);
    case ({duplex, cfgStrap})
      2'b00:   defaultLowPower = `FER_LOWPWR_RST_H0;
      2'b01:   defaultLowPower = `FER_LOWPWR_RST_H1;
      2'b10:   defaultLowPower = `FER_LOWPWR_RST_F0;
      default: defaultLowPower = `FER_LOWPWR_RST_F1;
    endcase
  endfunction : defaultLowPower

  // Register read-back decode; unmapped offsets read zero
  function automatic logic [7:0] readReg(input logic [6:0] addr,
                                         input logic [7:0] lowPwr,
                                         input logic [7:0] test,
                                         input logic [7:0] bias);
    case (addr)
      `FER_ADDR_LOWPWR: readReg = lowPwr;
      `FER_ADDR_TEST:   readReg = test;
      `FER_ADDR_BIAS:   readReg = bias;
      default:          readReg = 8'h00;  // Reset bit never stored
    endcase
  endfunction : readReg

  // Serial register port
  fer_serial_port #(
    .ADDR_W (ADDR_W),
    .DATA_W (DATA_W)
  ) uSerial (
    .clock             (clock),
    .rst               (rst),
    .serialClk         (serialClk),
    .serialPortEnableN (serialPortEnableN),
    .serialDataIn      (serialDataIn),
    .serialDataOut     (serialDataOut),
    .serialDataOeN     (serialDataOeN),
    .wrStrobe          (wrStrobe),
    .regAddr           (regAddr),
    .wrData            (wrData),
    .rdData            (rdData)
  );

  assign rdData = readReg(regAddr, lowPwr_q, test_q, bias_q);

  // Synchronise reset pin and the two straps
  always_comb
  begin
    pinMeta_d = {configSelPin, duplexSelPin, resetPinN};
    pinSync_d = pinMeta_q;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      pinMeta_q <= 3'h0;
      pinSync_q <= 3'h0;
    end
    else
    begin
      pinMeta_q <= pinMeta_d;
      pinSync_q <= pinSync_d;
    end
  end

  assign hwResetLow   = ~pinSync_q[0];
  // Pin low, software reset or start-up load the defaults
  assign loadDefaults = hwResetLow | swReset_q | (initCnt_q != 2'h0);

  // Reset sequencing: start-up load, software reset, calibration start
  always_comb
  begin
    resetPrev_d = pinSync_q[0];
    cal_d       = pinSync_q[0] & ~resetPrev_q;       // Rise of pin
    initCnt_d   = (initCnt_q != 2'h0) ? initCnt_q - 2'h1 : 2'h0;
    swReset_d   = wrStrobe & (regAddr == `FER_ADDR_SWRESET)
                & wrData[`FER_SWRESET_BIT];           // One cycle only
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      resetPrev_q <= 1'b0;
      cal_q       <= 1'b0;
      initCnt_q   <= `FER_INIT_CYCLES;
      swReset_q   <= 1'b0;
    end
    else
    begin
      resetPrev_q <= resetPrev_d;
      cal_q       <= cal_d;
      initCnt_q   <= initCnt_d;
      swReset_q   <= swReset_d;
    end
  end

  // Interface type follows the duplex strap while defaults load
  always_comb
  begin
    mode_d = mode_q;
    if (loadDefaults)
      mode_d = fer_pkg::fer_if_mode_t'(pinSync_q[1]);
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      mode_q <= fer_pkg::FER_IF_HALF;
    end
    else
    begin
      mode_q <= mode_d;
    end
  end

  // Register file; defaults win over writes while loading
  always_comb
  begin
    lowPwr_d = lowPwr_q;
    test_d   = test_q;
    bias_d   = bias_q;
    if (loadDefaults)
    begin
      lowPwr_d = defaultLowPower(pinSync_q[1], pinSync_q[2]);
      test_d   = `FER_TEST_RST;
      bias_d   = `FER_BIAS_RST;
    end
    else if (wrStrobe)
    begin
      case (regAddr)
        `FER_ADDR_LOWPWR: lowPwr_d = wrData;
        `FER_ADDR_TEST:   test_d   = wrData;
        `FER_ADDR_BIAS:   bias_d   = wrData;
        default:          ;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      lowPwr_q <= `FER_LOWPWR_RST_H0;
      test_q   <= `FER_TEST_RST;
      bias_q   <= `FER_BIAS_RST;
    end
    else
    begin
      lowPwr_q <= lowPwr_d;
      test_q   <= test_d;
      bias_q   <= bias_d;
    end
  end

  // Transmit filter feed; only system reset clears it, not pin or software reset
  always_comb
  begin
    filt_d = test_q[`FER_ALOOP_BIT] ? adcData : txPathData;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      filt_q <= 12'h000;
    end
    else
    begin
      filt_q <= filt_d;
    end
  end

  // Receive port: digital loopback in full duplex, optional float
  always_comb
  begin
    if (test_q[`FER_DLOOP_BIT] && mode_q == fer_pkg::FER_IF_FULL)
      rxPort_d = txPortData;
    else
      rxPort_d = rxCoreData;
    rxOeN_d = test_q[`FER_RXTRI_BIT];
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      rxPort_q <= 6'h00;
      rxOeN_q  <= 1'b1;
    end
    else
    begin
      rxPort_q <= rxPort_d;
      rxOeN_q  <= rxOeN_d;
    end
  end

  // Effective converter bias; low-power bit overrides the code
  always_comb
  begin
    if (lowPwr_q[`FER_LOWPWR_BIT])
      convBias_d = `FER_LOWPWR_BIAS;
    else
      convBias_d = bias_q[`FER_CONV_MSB:`FER_CONV_LSB];
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      convBias_q <= 3'h0;
    end
    else
    begin
      convBias_q <= convBias_d;
    end
  end

  // Outputs
  assign fullDuplexMode   = (mode_q == fer_pkg::FER_IF_FULL);
  assign calStart         = cal_q;
  assign interpFilterIn   = filt_q;
  assign rxPortData       = rxPort_q;
  assign rxPortOeN        = rxOeN_q;
  assign contGainBias     = bias_q[`FER_CGA_MSB:`FER_CGA_LSB];
  assign switchedGainBias = bias_q[`FER_SGA_MSB:`FER_SGA_LSB];
  assign convBias         = convBias_q;

endmodule : fer_ctrl

//--- design/fer_pkg.sv
package fer_pkg;

  // Serial port frame states, one-hot
  typedef enum logic [2:0] {
    FER_SP_IDLE  = 3'b001,
    FER_SP_INSTR = 3'b010,
    FER_SP_DATA  = 3'b100
  } fer_sp_state_t;

  // Data interface type chosen by the duplex strap
  typedef enum logic {
    FER_IF_HALF = 1'b0,
    FER_IF_FULL = 1'b1
  } fer_if_mode_t;

endpackage : fer_pkg

//--- design/fer_serial_port.sv
`timescale 1ns/1ps
`include "fer_cfg.svh"

module fer_serial_port #(
  parameter int ADDR_W = `FER_ADDR_W,
  parameter int DATA_W = `FER_DATA_W
)(
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              serialClk,
  input  wire logic              serialPortEnableN,
  input  wire logic              serialDataIn,
  output logic                   serialDataOut,
  output logic                   serialDataOeN,
  output logic                   wrStrobe,
  output logic [ADDR_W-1:0]      regAddr,
  output logic [DATA_W-1:0]      wrData,
  input  wire logic [DATA_W-1:0] rdData
);

  if (ADDR_W + 1 != DATA_W) begin : gBadWidth
    $error("fer_serial_port: instruction must be one byte");
  end

  logic [2:0]                 meta_q, meta_d;
  logic [2:0]                 sync_q, sync_d;
  logic                       clkPrev_q, clkPrev_d;
  fer_pkg::fer_sp_state_t     state_q, state_d;
  logic [3:0]                 count_q, count_d;
  logic [DATA_W-1:0]          shift_q, shift_d;
  logic [DATA_W-1:0]          out_q, out_d;
  logic                       read_q, read_d;
  logic [ADDR_W-1:0]          addr_q, addr_d;
  logic                       wr_q, wr_d;
  logic                       rise;
  logic                       enabled;

  // Two-stage synchronisers for clock, enable and data pins
  always_comb
  begin
    meta_d    = {serialClk, serialPortEnableN, serialDataIn};
    sync_d    = meta_q;
    clkPrev_d = sync_q[2];
  end

  assign rise    = sync_q[2] & ~clkPrev_q;
  assign enabled = ~sync_q[1];

  // Frame sequencer: 8-bit instruction then 8 data bits, MSB first
  always_comb
  begin
    state_d = state_q;
    count_d = count_q;
    shift_d = shift_q;
    out_d   = out_q;
    read_d  = read_q;
    addr_d  = addr_q;
    wr_d    = 1'b0;
    case (state_q)
      fer_pkg::FER_SP_IDLE:
      begin
        count_d = 4'h0;
        if (enabled)               // Enable held high keeps port dead
          state_d = fer_pkg::FER_SP_INSTR;
      end
      fer_pkg::FER_SP_INSTR:
      begin
        if (!enabled)
          state_d = fer_pkg::FER_SP_IDLE;
        else if (rise)
        begin
          shift_d = {shift_q[DATA_W-2:0], sync_q[0]};
          count_d = count_q + 4'h1;
          if (count_q == 4'h7)
          begin
            read_d  = shift_q[DATA_W-2];
            addr_d  = {shift_q[ADDR_W-2:0], sync_q[0]};
            count_d = 4'h0;
            state_d = fer_pkg::FER_SP_DATA;
          end
        end
      end
      fer_pkg::FER_SP_DATA:
      begin
        if (count_q == 4'h0 && read_q)
          out_d = rdData;
        if (!enabled)
          state_d = fer_pkg::FER_SP_IDLE;
        else if (rise)
        begin
          shift_d = {shift_q[DATA_W-2:0], sync_q[0]};
          out_d   = {out_q[DATA_W-2:0], 1'b0};
          count_d = count_q + 4'h1;
          if (count_q == 4'h7)
          begin
            wr_d    = ~read_q;
            count_d = 4'h0;
            state_d = fer_pkg::FER_SP_INSTR;
          end
        end
      end
      default:
        state_d = fer_pkg::FER_SP_IDLE;
    endcase
  end

  // Port registers
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      meta_q    <= 3'h2;
      sync_q    <= 3'h2;
      clkPrev_q <= 1'b0;
      state_q   <= fer_pkg::FER_SP_IDLE;
      count_q   <= 4'h0;
      shift_q   <= '0;
      out_q     <= '0;
      read_q    <= 1'b0;
      addr_q    <= '0;
      wr_q      <= 1'b0;
    end
    else
    begin
      meta_q    <= meta_d;
      sync_q    <= sync_d;
      clkPrev_q <= clkPrev_d;
      state_q   <= state_d;
      count_q   <= count_d;
      shift_q   <= shift_d;
      out_q     <= out_d;
      read_q    <= read_d;
      addr_q    <= addr_d;
      wr_q      <= wr_d;
    end
  end

  // Drive data line only during read data phase
  assign serialDataOut = out_q[DATA_W-1];
  assign serialDataOeN = ~((state_q == fer_pkg::FER_SP_DATA) & read_q);
  assign wrStrobe      = wr_q;
  assign regAddr       = addr_q;
  assign wrData        = shift_q;

endmodule : fer_serial_port

//--- testbench/fer_ctrl_sva.sv
`timescale 1ns/1ps
module fer_ctrl_sva (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        resetPinN,
  input wire logic        duplexSelPin,
  input wire logic        serialPortEnableN,
  input wire logic        serialDataOeN,
  input wire logic        fullDuplexMode,
  input wire logic        calStart,
  input wire logic        rxPortOeN,
  input wire logic [11:0] txPathData,
  input wire logic [11:0] interpFilterIn,
  input wire logic [2:0]  contGainBias,
  input wire logic [1:0]  switchedGainBias,
  input wire logic [2:0]  convBias
);
  logic [3:0] idleCnt;
  logic [3:0] evtCnt;

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  // Quiet serial port time and time since the last release event
  always_ff @(posedge clock)
  begin
    if (rst || !serialPortEnableN || !resetPinN)
      idleCnt <= 4'h0;
    else if (idleCnt != 4'hf)
      idleCnt <= idleCnt + 4'h1;
    if (rst || $rose(resetPinN))
      evtCnt <= 4'h0;
    else if (evtCnt != 4'hf)
      evtCnt <= evtCnt + 4'h1;
  end

  rstValues_a:
    assert property ($fell(rst) |-> rxPortOeN && serialDataOeN && !calStart)
    else $error("outputs not at reset values");
  pinDefaults_a:
    assert property ((!resetPinN)[*5] |->
      contGainBias == 3'h0 && switchedGainBias == 2'h0 && convBias == 3'h0)
    else $error("bias fields not default while pin low");
  calOnRise_a:
    assert property ($rose(resetPinN) |-> ##[2:4] calStart)
    else $error("no calibration start after pin release");
  calCause_a:
    assert property (calStart |-> evtCnt <= 4'h6)
    else $error("calibration start without pin release");
  calPulse_a:
    assert property (calStart |=> !calStart)
    else $error("calibration start longer than one cycle");
  duplexStrap_a:
    assert property ((!resetPinN && $stable(duplexSelPin))[*6] |->
      fullDuplexMode == duplexSelPin)
    else $error("interface type does not follow strap");
  idleStable_a:
    assert property (idleCnt >= 4'ha |-> $stable(contGainBias) &&
      $stable(switchedGainBias) && $stable(convBias))
    else $error("bias changed with serial port unused");
  lineRelease_a:
    assert property (serialPortEnableN[*5] |-> serialDataOeN)
    else $error("data line driven with port disabled");
  filterKept_a:
    assert property ((!resetPinN)[*5] |->
      interpFilterIn == $past(txPathData))
    else $error("transmit filter feed disturbed by pin reset");

  cover property (calStart);
  cover property (!serialDataOeN);
  cover property (rxPortOeN && resetPinN);
  cover property (convBias == 3'h3);
endmodule : fer_ctrl_sva

bind fer_ctrl fer_ctrl_sva fer_ctrl_sva_inst (
  .clock(clock), .rst(rst), .resetPinN(resetPinN),
  .duplexSelPin(duplexSelPin), .serialPortEnableN(serialPortEnableN),
  .serialDataOeN(serialDataOeN), .fullDuplexMode(fullDuplexMode),
  .calStart(calStart), .rxPortOeN(rxPortOeN), .txPathData(txPathData),
  .interpFilterIn(interpFilterIn), .contGainBias(contGainBias),
  .switchedGainBias(switchedGainBias), .convBias(convBias)
);

//--- testbench/fer_host_model.sv
`timescale 1ns/1ps
module fer_host_model #(
  parameter int HALF       = 5,
  parameter int PWR_UP_CYC = 20
)(
  input  wire logic clock,
  input  wire logic serialDataOut,
  input  wire logic serialDataOeN,
  output logic      serialClk,
  output logic      serialPortEnableN,
  output logic      serialDataIn,
  output logic      resetPinN
);
  logic       hostBit;
  logic [7:0] rdVal;

  // Data line level: the device wins while it drives
  assign serialDataIn = serialDataOeN ? hostBit : serialDataOut;

  // Power-up hold, shortened from 10 ms to keep the run short
  initial
  begin
    serialClk = 1'b0;
    serialPortEnableN = 1'b1;
    hostBit = 1'b0;
    resetPinN = 1'b0;
    repeat (PWR_UP_CYC) @(negedge clock);
    resetPinN = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask : tick

  // One 16-bit frame; in a read the host line toggles, never holds
  task automatic xfer(input logic rd, input logic [6:0] a,
                      input logic [7:0] d);
    logic [15:0] f;
    f = {rd, a, d};
    serialPortEnableN = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      serialClk = 1'b0;
      hostBit = (rd && i < 8) ? ~hostBit : f[i];
      tick(HALF);
      if (i < 8)
        rdVal[i] = serialDataIn;
      serialClk = 1'b1;
      tick(HALF);
    end
    serialClk = 1'b0;
    tick(HALF);
    serialPortEnableN = 1'b1;
    tick(HALF);
  endtask : xfer

  // Clock and data toggled while the enable stays high
  task automatic idleBurst(input logic [15:0] f);
    for (int i = 15; i >= 0; i--)
    begin
      serialClk = 1'b0;
      hostBit = f[i];
      tick(HALF);
      serialClk = 1'b1;
      tick(HALF);
    end
    serialClk = 1'b0;
    tick(HALF);
  endtask : idleBurst

  // Pin reset pulse, at least 5 cycles low
  task automatic pinReset(input int lowCyc);
    resetPinN = 1'b0;
    tick(lowCyc);
    resetPinN = 1'b1;
    tick(8);
  endtask : pinReset
endmodule : fer_host_model

//--- testbench/tb_fer_ctrl.sv
`timescale 1ns/1ps
module tb_fer_ctrl;
  logic        clock = 1'b0;
  logic        rst;
  logic        resetPinN;
  logic        duplexSelPin;
  logic        configSelPin;
  logic        serialClk;
  logic        serialPortEnableN;
  logic        serialDataIn;
  logic        serialDataOut;
  logic        serialDataOeN;
  logic [5:0]  txPortData;
  logic [5:0]  rxCoreData;
  logic [11:0] txPathData;
  logic [11:0] adcData;
  logic        fullDuplexMode;
  logic        calStart;
  logic [11:0] interpFilterIn;
  logic [5:0]  rxPortData;
  logic        rxPortOeN;
  logic [2:0]  contGainBias;
  logic [1:0]  switchedGainBias;
  logic [2:0]  convBias;
  logic [11:0] expQ[$];
  logic [11:0] gotQ[$];
  string       nameQ[$];
  int          n_errors = 0;
  int          tests_run = 0;
  int          calCnt = 0;
  int          c0;
  logic [7:0]  v;
  logic [5:0]  e;

  fer_ctrl fer_ctrl_inst (.clock(clock), .rst(rst), .resetPinN(resetPinN),
    .duplexSelPin(duplexSelPin), .configSelPin(configSelPin),
    .serialClk(serialClk), .serialPortEnableN(serialPortEnableN),
    .serialDataIn(serialDataIn), .serialDataOut(serialDataOut),
    .serialDataOeN(serialDataOeN), .txPortData(txPortData),
    .rxCoreData(rxCoreData), .txPathData(txPathData), .adcData(adcData),
    .fullDuplexMode(fullDuplexMode), .calStart(calStart),
    .interpFilterIn(interpFilterIn), .rxPortData(rxPortData),
    .rxPortOeN(rxPortOeN), .contGainBias(contGainBias),
    .switchedGainBias(switchedGainBias), .convBias(convBias));

  fer_host_model #(.HALF(5), .PWR_UP_CYC(20)) fer_host_model_inst (
    .clock(clock), .serialDataOut(serialDataOut),
    .serialDataOeN(serialDataOeN), .serialClk(serialClk),
    .serialPortEnableN(serialPortEnableN), .serialDataIn(serialDataIn),
    .resetPinN(resetPinN));

  always #5 clock = ~clock;

  task automatic check(string nm, logic [11:0] seen, logic [11:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up

  // Note an expectation together with the value seen now
  task automatic look(string nm, logic [11:0] seen, logic [11:0] exp);
    nameQ.push_back(nm);
    expQ.push_back(exp);
    gotQ.push_back(seen);
  endtask : look

  // Register read; the note goes in before the frame starts
  task automatic rd(logic [6:0] a, logic [7:0] x);
    nameQ.push_back("regRead");
    expQ.push_back({4'h0, x});
    fer_host_model_inst.xfer(1'b1, a, 8'h00);
    gotQ.push_back({4'h0, fer_host_model_inst.rdVal});
  endtask : rd

  // Pair each result with the oldest note
  always @(posedge clock)
    if (gotQ.size() > 0)
      check(nameQ.pop_front(), gotQ.pop_front(), expQ.pop_front());

  // Count calibration starts
  always @(posedge clock)
    if (calStart === 1'b1)
      calCnt++;

  // Watchdog
  initial
  begin
    #200us;
    n_errors++;
    wrap_up();
  end

  initial
  begin
    rst = 1'b1;
    duplexSelPin = 1'b1;
    configSelPin = 1'b0;
    txPortData = 6'h00;
    rxCoreData = 6'h00;
    txPathData = 12'h000;
    adcData = 12'h000;
    void'($urandom(32'h2249));
    repeat (4) @(negedge clock);
    rst = 1'b0;
    wait (resetPinN === 1'b1);
    repeat (10) @(negedge clock);
    rd(7'h13, 8'h00);
    rd(7'h0d, 8'h00);
    rd(7'h55, 8'h00);
    v = 8'($urandom);
    fer_host_model_inst.xfer(1'b0, 7'h13, v);
    fer_host_model_inst.idleBurst({1'b0, 7'h13, ~v});
    rd(7'h13, v);
    look("ctBias", 12'(contGainBias), 12'(v[7:5]));
    look("scBias", 12'(switchedGainBias), 12'(v[4:3]));
    fer_host_model_inst.xfer(1'b0, 7'h07, 8'h10);
    look("convLow", 12'(convBias), 12'h003);
    fer_host_model_inst.xfer(1'b0, 7'h07, 8'h00);
    look("convBias", 12'(convBias), 12'(v[2:0]));
    // Software reset: defaults back, no calibration, bit self-clears
    c0 = calCnt;
    fer_host_model_inst.xfer(1'b0, 7'h00, 8'h20);
    rd(7'h00, 8'h00);
    look("swBias", 12'({contGainBias, convBias}), 12'h000);
    look("swCal", 12'(calCnt), 12'(c0));
    // Pin reset and test modes under both interface types
    for (int m = 0; m < 2; m++)
    begin
      duplexSelPin = m[0];
      configSelPin = m[0];
      fer_host_model_inst.xfer(1'b0, 7'h13, v);
      c0 = calCnt;
      txPathData = 12'($urandom);
      fer_host_model_inst.pinReset(6);
      look("duplex", 12'(fullDuplexMode), 12'(m[0]));
      look("pinCal", 12'(calCnt), 12'(c0 + 1));
      rd(7'h13, 8'h00);
      @(negedge clock);
      look("filterFeed", interpFilterIn, txPathData);
      fer_host_model_inst.xfer(1'b0, 7'h0d, 8'h80);
      adcData = 12'($urandom);
      @(negedge clock);
      look("analogLoop", interpFilterIn, adcData);
      fer_host_model_inst.xfer(1'b0, 7'h0d, 8'h40);
      txPortData = 6'($urandom);
      rxCoreData = ~txPortData;
      e = m[0] ? txPortData : rxCoreData;
      @(negedge clock);
      look("digitalLoop", 12'(rxPortData), 12'(e));
      fer_host_model_inst.xfer(1'b0, 7'h0d, 8'h20);
      look("rxFloat", 12'(rxPortOeN), 12'h001);
      fer_host_model_inst.xfer(1'b0, 7'h0d, 8'h00);
      look("rxDriven", 12'(rxPortOeN), 12'h000);
    end
    repeat (20) @(negedge clock);
    wrap_up();
  end
endmodule : tb_fer_ctrl
